// ### design/badp_top.sv
// badp_top: register file, area decode, bus width split and byte-lane parity of the bus controller.
// assumes an AXI4-Lite master on ref_clk, a cpu port on ref_clk and pins from outside the domain.
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
module badp_top (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire badp_pkg::badp_cpu_req_t cpu_req,
	output logic cpu_ready,
	output badp_pkg::badp_cpu_rsp_t cpu_rsp,
	input wire logic [2:0] boot_mode_pins,
	input wire badp_pkg::badp_ext_in_t ext_in,
	output badp_pkg::badp_ext_out_t ext_out,
	output badp_pkg::badp_refresh_t refresh_regs
);

	typedef enum logic [3:0] {
		BADP_ST_IDLE = 4'h1,
		BADP_ST_SETUP = 4'h2,
		BADP_ST_STROBE = 4'h4,
		BADP_ST_NEXT = 4'h8
	} badp_bus_st_t;

	typedef struct packed {
		logic aw_held;
		logic [7:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic parity_error_flag;
		logic parity_force_high;
		logic parity_odd_select;
		logic parity_space_sel_hi;
		logic parity_space_sel_lo;
		logic pef_armed;
		badp_pkg::badp_refresh_t rf;
		logic [15:0] ad_s1;
		logic [15:0] ad_s2;
		logic [1:0] par_s1;
		logic [1:0] par_s2;
		logic [2:0] md_s1;
		logic [2:0] md_s2;
		badp_bus_st_t st;
		logic [27:0] addr;
		logic write;
		badp_pkg::badp_size_t size;
		badp_pkg::badp_width_t width;
		logic [31:0] wsh;
		logic [31:0] racc;
		logic [2:0] beats_left;
		logic [3:0] cnt;
		logic par_en;
		badp_pkg::badp_ext_out_t ext;
		badp_pkg::badp_cpu_rsp_t rsp;
	} badp_state_t;

	badp_state_t s_q;
	badp_state_t s_d;

	// bus width of one access from its area and the overriding conditions
	function automatic badp_pkg::badp_width_t area_width(input logic [27:0] a, input logic [2:0] md);
		logic a27;
		a27 = a[badp_pkg::BADP_A_WIDTH_BIT];
		case (a[badp_pkg::BADP_A_AREA_HI:badp_pkg::BADP_A_AREA_LO])
			badp_pkg::BADP_AREA_ROM: begin
				if (md == badp_pkg::BADP_MD_ROM32) area_width = badp_pkg::BADP_W32;
				else if (md == badp_pkg::BADP_MD_EXT16) area_width = badp_pkg::BADP_W16;
				else area_width = badp_pkg::BADP_W8;
			end
			badp_pkg::BADP_AREA_MODULE: begin
				if (a27 || a[badp_pkg::BADP_A_MOD_W_BIT]) area_width = badp_pkg::BADP_W16;
				else area_width = badp_pkg::BADP_W8;
			end
			badp_pkg::BADP_AREA_6: begin
				if (a27 || a[badp_pkg::BADP_A_A6_W_BIT]) area_width = badp_pkg::BADP_W16;
				else area_width = badp_pkg::BADP_W8;
			end
			badp_pkg::BADP_AREA_RAM: begin
				area_width = a27 ? badp_pkg::BADP_W32 : badp_pkg::BADP_W8;
			end
			default: begin
				area_width = a27 ? badp_pkg::BADP_W16 : badp_pkg::BADP_W8;
			end
		endcase
	endfunction : area_width

	// on-chip spaces never run an external cycle
	function automatic logic is_internal(input logic [27:0] a, input logic [2:0] md);
		logic [2:0] ar;
		ar = a[badp_pkg::BADP_A_AREA_HI:badp_pkg::BADP_A_AREA_LO];
		is_internal = (ar == badp_pkg::BADP_AREA_ROM && md == badp_pkg::BADP_MD_ROM32)
			|| (ar == badp_pkg::BADP_AREA_MODULE && !a[badp_pkg::BADP_A_WIDTH_BIT])
			|| (ar == badp_pkg::BADP_AREA_RAM && a[badp_pkg::BADP_A_WIDTH_BIT]);
	endfunction : is_internal

	// parity bit of one byte lane under the selected polarity
	function automatic logic lane_parity(input logic [7:0] b, input logic odd);
		lane_parity = (^b) ^ odd;
	endfunction : lane_parity

	function automatic logic [2:0] beat_count(input badp_pkg::badp_size_t sz,
		input badp_pkg::badp_width_t w);
		case (sz)
			badp_pkg::BADP_SZ_WORD: beat_count = (w == badp_pkg::BADP_W8) ? 3'h2 : 3'h1;
			badp_pkg::BADP_SZ_LONG: begin
				if (w == badp_pkg::BADP_W8) beat_count = 3'h4;
				else if (w == badp_pkg::BADP_W16) beat_count = 3'h2;
				else beat_count = 3'h1;
			end
			default: beat_count = 3'h1;
		endcase
	endfunction : beat_count

	assign s_axi_awready = !s_q.aw_held;
	assign s_axi_wready = !s_q.w_held;
	assign s_axi_arready = !s_q.rvalid;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;
	assign cpu_ready = (s_q.st == BADP_ST_IDLE);
	assign cpu_rsp = s_q.rsp;
	assign ext_out = s_q.ext;
	assign refresh_regs = s_q.rf;

	always_comb begin
		logic [15:0] pcr_rd;
		logic word_wr;
		logic [7:0] key;
		logic [7:0] wlo;
		logic perr;
		logic [1:0] lanes;
		logic [1:0] pspace;
		logic [2:0] area;
		logic [27:0] a;
		logic last;
		badp_pkg::badp_width_t w;
		pcr_rd = 16'h0000;
		word_wr = 1'b0;
		key = 8'h00;
		wlo = 8'h00;
		perr = 1'b0;
		lanes = 2'h0;
		pspace = 2'h0;
		area = 3'h0;
		a = 28'h0000000;
		last = 1'b0;
		w = badp_pkg::BADP_W8;
		s_d = s_q;

		// two-stage synchronisers for everything arriving on pins
		s_d.ad_s1 = ext_in.muxed_addr_data_pins_in;
		s_d.ad_s2 = s_q.ad_s1;
		s_d.par_s1 = {ext_in.parity_pin_upper_lane_in, ext_in.parity_pin_lower_lane_in};
		s_d.par_s2 = s_q.par_s1;
		s_d.md_s1 = boot_mode_pins;
		s_d.md_s2 = s_q.md_s1;
		s_d.rsp.done = 1'b0;

		// bits 10..0 are never stored, so they read zero
		pcr_rd[badp_pkg::BADP_PEF_BIT] = s_q.parity_error_flag;
		pcr_rd[badp_pkg::BADP_PARITY_FORCE_HIGH_BIT] = s_q.parity_force_high;
		pcr_rd[badp_pkg::BADP_PEO_BIT] = s_q.parity_odd_select;
		pcr_rd[badp_pkg::BADP_PCHK_HI_BIT] = s_q.parity_space_sel_hi;
		pcr_rd[badp_pkg::BADP_PCHK_LO_BIT] = s_q.parity_space_sel_lo;
		pspace = {s_q.parity_space_sel_hi, s_q.parity_space_sel_lo};

		// axi write channels, taken in either order
		if (s_axi_awvalid && !s_q.aw_held) begin
			s_d.aw_held = 1'b1;
			s_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_q.w_held) begin
			s_d.w_held = 1'b1;
			s_d.w_data = s_axi_wdata;
			s_d.w_strb = s_axi_wstrb;
		end
		if (s_q.bvalid && s_axi_bready) s_d.bvalid = 1'b0;

		if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
			s_d.aw_held = 1'b0;
			s_d.w_held = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = badp_pkg::BADP_RESP_OKAY;
			word_wr = (s_q.w_strb[1:0] == 2'h3);
			key = s_q.w_data[15:8];
			wlo = s_q.w_data[7:0];
			case ({s_q.aw_addr[7:2], 2'h0})
				badp_pkg::BADP_OFS_PARITY_CTL: begin
					if (s_q.w_strb[1]) begin
						s_d.parity_force_high = s_q.w_data[badp_pkg::BADP_PARITY_FORCE_HIGH_BIT];
						s_d.parity_odd_select = s_q.w_data[badp_pkg::BADP_PEO_BIT];
						s_d.parity_space_sel_hi = s_q.w_data[badp_pkg::BADP_PCHK_HI_BIT];
						s_d.parity_space_sel_lo = s_q.w_data[badp_pkg::BADP_PCHK_LO_BIT];
						// writing one never sets the flag; zero clears it only once armed
						if (!s_q.w_data[badp_pkg::BADP_PEF_BIT] && s_q.pef_armed) begin
							s_d.parity_error_flag = 1'b0;
							s_d.pef_armed = 1'b0;
						end
					end
				end
				badp_pkg::BADP_OFS_REFRESH_CTL: begin
					if (word_wr && key == badp_pkg::BADP_KEY_REFRESH_CTL) begin
						s_d.rf.refresh_control_reg = wlo;
					end
				end
				badp_pkg::BADP_OFS_REFRESH_TCS: begin
					if (word_wr && key == badp_pkg::BADP_KEY_REFRESH_TCS) begin
						s_d.rf.refresh_timer_ctl_status = wlo;
					end
				end
				badp_pkg::BADP_OFS_REFRESH_CNT: begin
					if (word_wr && key == badp_pkg::BADP_KEY_REFRESH_CNT) begin
						s_d.rf.refresh_counter = wlo;
					end
				end
				badp_pkg::BADP_OFS_REFRESH_CONST: begin
					if (word_wr && key == badp_pkg::BADP_KEY_REFRESH_CONST) begin
						s_d.rf.refresh_constant = wlo;
					end
				end
				badp_pkg::BADP_OFS_BUS_CTL: begin
					if (s_q.w_strb[0]) s_d.rf.dram_space_enable = s_q.w_data[badp_pkg::BADP_DRAM_SPACE_ENABLE_BIT];
				end
				default: begin
					s_d.bresp = badp_pkg::BADP_RESP_SLVERR;
				end
			endcase
		end

		// axi read; byte and word reads alike return the full word
		if (s_q.rvalid && s_axi_rready) s_d.rvalid = 1'b0;
		if (s_axi_arvalid && !s_q.rvalid) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = badp_pkg::BADP_RESP_OKAY;
			s_d.rdata = 32'h00000000;
			case ({s_axi_araddr[7:2], 2'h0})
				badp_pkg::BADP_OFS_PARITY_CTL: begin
					s_d.rdata[15:0] = pcr_rd;
					if (s_q.parity_error_flag) s_d.pef_armed = 1'b1;
				end
				badp_pkg::BADP_OFS_REFRESH_CTL: s_d.rdata[7:0] = s_q.rf.refresh_control_reg;
				badp_pkg::BADP_OFS_REFRESH_TCS: s_d.rdata[7:0] = s_q.rf.refresh_timer_ctl_status;
				badp_pkg::BADP_OFS_REFRESH_CNT: s_d.rdata[7:0] = s_q.rf.refresh_counter;
				badp_pkg::BADP_OFS_REFRESH_CONST: s_d.rdata[7:0] = s_q.rf.refresh_constant;
				badp_pkg::BADP_OFS_BUS_CTL: s_d.rdata[badp_pkg::BADP_DRAM_SPACE_ENABLE_BIT] = s_q.rf.dram_space_enable;
				default: s_d.rresp = badp_pkg::BADP_RESP_SLVERR;
			endcase
		end

		// external bus sequencer
		a = s_q.addr;
		area = a[badp_pkg::BADP_A_AREA_HI:badp_pkg::BADP_A_AREA_LO];
		if (s_q.width == badp_pkg::BADP_W8) lanes = 2'h1;
		else if (s_q.size != badp_pkg::BADP_SZ_BYTE) lanes = 2'h3;
		else lanes = a[0] ? 2'h1 : 2'h2;
		case (s_q.st)
			BADP_ST_IDLE: begin
				if (cpu_req.valid) begin
					// upper nibble of the cpu address is dropped here for good
					a = cpu_req.addr[27:0];
					w = area_width(a, s_q.md_s2);
					s_d.addr = a;
					s_d.write = cpu_req.write;
					s_d.size = cpu_req.size;
					s_d.width = w;
					s_d.racc = 32'h00000000;
					s_d.beats_left = beat_count(cpu_req.size, w);
					case (cpu_req.size)
						badp_pkg::BADP_SZ_BYTE: s_d.wsh = {cpu_req.wdata[7:0], 24'h000000};
						badp_pkg::BADP_SZ_WORD: s_d.wsh = {cpu_req.wdata[15:0], 16'h0000};
						default: s_d.wsh = cpu_req.wdata;
					endcase
					area = a[badp_pkg::BADP_A_AREA_HI:badp_pkg::BADP_A_AREA_LO];
					s_d.par_en = (area == badp_pkg::BADP_AREA_DRAM && s_q.rf.dram_space_enable
						&& (pspace == badp_pkg::BADP_PSPACE_DRAM || pspace == badp_pkg::BADP_PSPACE_DRAM_A2))
						|| (area == badp_pkg::BADP_AREA_2 && pspace == badp_pkg::BADP_PSPACE_DRAM_A2);
					if (is_internal(a, s_q.md_s2)) begin
						// on-chip targets are answered here; no pin moves
						s_d.rsp.done = 1'b1;
						s_d.rsp.internal = 1'b1;
						s_d.rsp.rdata = 32'h00000000;
						// longword to 8-bit module registers is inhibited and flagged
						s_d.rsp.err = (area == badp_pkg::BADP_AREA_MODULE && w == badp_pkg::BADP_W8
							&& cpu_req.size == badp_pkg::BADP_SZ_LONG);
					end else begin
						s_d.st = BADP_ST_SETUP;
					end
				end
			end
			BADP_ST_SETUP: begin
				s_d.ext.addr = a;
				if (area == badp_pkg::BADP_AREA_DRAM && s_q.rf.dram_space_enable) begin
					s_d.ext.ras_n = 1'b0;
				end else begin
					s_d.ext.area_select_n = ~(8'h01 << area);
				end
				s_d.cnt = badp_pkg::BADP_STROBE_CYC;
				s_d.st = BADP_ST_STROBE;
				if (s_q.write) begin
					s_d.ext.muxed_addr_data_pins_oe = {{8{lanes[1]}}, {8{lanes[0]}}};
					if (lanes == 2'h3) s_d.ext.muxed_addr_data_pins_out = s_q.wsh[31:16];
					else if (lanes == 2'h2) s_d.ext.muxed_addr_data_pins_out = {s_q.wsh[31:24], 8'h00};
					else s_d.ext.muxed_addr_data_pins_out = {8'h00, s_q.wsh[31:24]};
					if (s_q.par_en) begin
						// forced high overrides the computed lane parity for checker tests
						s_d.ext.parity_pin_upper_lane_oe = lanes[1];
						s_d.ext.parity_pin_lower_lane_oe = lanes[0];
						s_d.ext.parity_pin_upper_lane_out = s_q.parity_force_high
							|| lane_parity(s_d.ext.muxed_addr_data_pins_out[15:8], s_q.parity_odd_select);
						s_d.ext.parity_pin_lower_lane_out = s_q.parity_force_high
							|| lane_parity(s_d.ext.muxed_addr_data_pins_out[7:0], s_q.parity_odd_select);
					end
				end
			end
			BADP_ST_STROBE: begin
				s_d.ext.rd_n = s_q.write;
				s_d.ext.wr_n = !s_q.write;
				if (area == badp_pkg::BADP_AREA_DRAM && s_q.rf.dram_space_enable) s_d.ext.cas_n = 1'b0;
				s_d.cnt = s_q.cnt - 4'h1;
				if (s_q.cnt == 4'h1) begin
					s_d.st = BADP_ST_NEXT;
					if (!s_q.write) begin
						if (lanes == 2'h3) s_d.racc = {s_q.racc[15:0], s_q.ad_s2};
						else if (lanes == 2'h2) s_d.racc = {s_q.racc[23:0], s_q.ad_s2[15:8]};
						else s_d.racc = {s_q.racc[23:0], s_q.ad_s2[7:0]};
						if (s_q.par_en) begin
							perr = (lanes[1] && (s_q.par_s2[1]
								!= lane_parity(s_q.ad_s2[15:8], s_q.parity_odd_select)))
								|| (lanes[0] && (s_q.par_s2[0]
								!= lane_parity(s_q.ad_s2[7:0], s_q.parity_odd_select)));
						end
					end
				end
			end
			BADP_ST_NEXT: begin
				// release the bus for one cycle between split beats
				s_d.ext.area_select_n = 8'hff;
				s_d.ext.ras_n = 1'b1;
				s_d.ext.cas_n = 1'b1;
				s_d.ext.rd_n = 1'b1;
				s_d.ext.wr_n = 1'b1;
				s_d.ext.muxed_addr_data_pins_oe = 16'h0000;
				s_d.ext.parity_pin_upper_lane_oe = 1'b0;
				s_d.ext.parity_pin_lower_lane_oe = 1'b0;
				last = (s_q.beats_left == 3'h1);
				s_d.beats_left = s_q.beats_left - 3'h1;
				if (last) begin
					s_d.st = BADP_ST_IDLE;
					s_d.rsp.done = 1'b1;
					s_d.rsp.internal = 1'b0;
					s_d.rsp.err = 1'b0;
					s_d.rsp.rdata = s_q.racc;
				end else begin
					s_d.st = BADP_ST_SETUP;
					if (s_q.width == badp_pkg::BADP_W8) begin
						s_d.addr = s_q.addr + 28'h0000001;
						s_d.wsh = {s_q.wsh[23:0], 8'h00};
					end else begin
						s_d.addr = s_q.addr + 28'h0000002;
						s_d.wsh = {s_q.wsh[15:0], 16'h0000};
					end
				end
			end
			default: begin
				s_d.st = BADP_ST_IDLE;
			end
		endcase

		// hardware set wins over a software clear in the same cycle
		if (perr) s_d.parity_error_flag = 1'b1;
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			// power-on reset is the only reset this block sees
			s_q <= '0;
			s_q.rf.refresh_constant <= badp_pkg::BADP_RST_REFRESH_CONST;
			s_q.rf.refresh_counter <= badp_pkg::BADP_RST_ZERO8;
			s_q.st <= BADP_ST_IDLE;
			s_q.ext.area_select_n <= 8'hff;
			s_q.ext.ras_n <= 1'b1;
			s_q.ext.cas_n <= 1'b1;
			s_q.ext.rd_n <= 1'b1;
			s_q.ext.wr_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

endmodule : badp_top

// ### design/badp_pkg.sv
// badp_pkg: constants, register map and carrier types of the bus area decode and parity block.
// assumes a 32-bit AXI4-Lite register port and one 125 MHz clock for the whole block.
package badp_pkg;

	// register byte offsets on the AXI4-Lite port
	localparam logic [7:0] BADP_OFS_PARITY_CTL = 8'h00;
	localparam logic [7:0] BADP_OFS_REFRESH_CTL = 8'h04;
	localparam logic [7:0] BADP_OFS_REFRESH_TCS = 8'h08;
	localparam logic [7:0] BADP_OFS_REFRESH_CNT = 8'h0c;
	localparam logic [7:0] BADP_OFS_REFRESH_CONST = 8'h10;
	localparam logic [7:0] BADP_OFS_BUS_CTL = 8'h14;

	// parity control and bus control field positions
	localparam int unsigned BADP_PEF_BIT = 15;
	localparam int unsigned BADP_PARITY_FORCE_HIGH_BIT = 14;
	localparam int unsigned BADP_PEO_BIT = 13;
	localparam int unsigned BADP_PCHK_HI_BIT = 12;
	localparam int unsigned BADP_PCHK_LO_BIT = 11;
	localparam int unsigned BADP_DRAM_SPACE_ENABLE_BIT = 0;

	// parity space selections
	localparam logic [1:0] BADP_PSPACE_NONE = 2'h0;
	localparam logic [1:0] BADP_PSPACE_DRAM = 2'h1;
	localparam logic [1:0] BADP_PSPACE_DRAM_A2 = 2'h2;

	// write keys of the protected refresh group
	localparam logic [7:0] BADP_KEY_REFRESH_CTL = 8'h5a;
	localparam logic [7:0] BADP_KEY_REFRESH_TCS = 8'ha5;
	localparam logic [7:0] BADP_KEY_REFRESH_CNT = 8'h69;
	localparam logic [7:0] BADP_KEY_REFRESH_CONST = 8'h96;

	// reset values
	localparam logic [7:0] BADP_RST_REFRESH_CONST = 8'hff;
	localparam logic [7:0] BADP_RST_ZERO8 = 8'h00;

	// boot mode pin codes for area 0
	localparam logic [2:0] BADP_MD_EXT8 = 3'h0;
	localparam logic [2:0] BADP_MD_EXT16 = 3'h1;
	localparam logic [2:0] BADP_MD_ROM32 = 3'h2;

	// areas with special decode
	localparam logic [2:0] BADP_AREA_ROM = 3'h0;
	localparam logic [2:0] BADP_AREA_DRAM = 3'h1;
	localparam logic [2:0] BADP_AREA_2 = 3'h2;
	localparam logic [2:0] BADP_AREA_MODULE = 3'h5;
	localparam logic [2:0] BADP_AREA_6 = 3'h6;
	localparam logic [2:0] BADP_AREA_RAM = 3'h7;

	// address bit positions
	localparam int unsigned BADP_A_WIDTH_BIT = 27;
	localparam int unsigned BADP_A_AREA_HI = 26;
	localparam int unsigned BADP_A_AREA_LO = 24;
	localparam int unsigned BADP_A_MOD_W_BIT = 8;
	localparam int unsigned BADP_A_A6_W_BIT = 14;

	// external cycle timing: strobe time and its cycle count at 125 MHz
	localparam int unsigned BADP_CLK_MHZ = 125;
	localparam int unsigned BADP_STROBE_NS = 32;
	localparam logic [3:0] BADP_STROBE_CYC = 4'((BADP_STROBE_NS * BADP_CLK_MHZ + 999) / 1000);

	localparam logic [1:0] BADP_RESP_OKAY = 2'h0;
	localparam logic [1:0] BADP_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {BADP_SZ_BYTE = 2'h0, BADP_SZ_WORD = 2'h1, BADP_SZ_LONG = 2'h2} badp_size_t;
	typedef enum logic [1:0] {BADP_W8 = 2'h0, BADP_W16 = 2'h1, BADP_W32 = 2'h2} badp_width_t;

	typedef struct packed {
		logic valid;
		logic write;
		badp_size_t size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} badp_cpu_req_t;

	typedef struct packed {
		logic done;
		logic internal;
		logic err;
		logic [31:0] rdata;
	} badp_cpu_rsp_t;

	typedef struct packed {
		logic [27:0] addr;
		logic [7:0] area_select_n;
		logic ras_n;
		logic cas_n;
		logic rd_n;
		logic wr_n;
		logic [15:0] muxed_addr_data_pins_out;
		logic [15:0] muxed_addr_data_pins_oe;
		logic parity_pin_upper_lane_out;
		logic parity_pin_upper_lane_oe;
		logic parity_pin_lower_lane_out;
		logic parity_pin_lower_lane_oe;
	} badp_ext_out_t;

	typedef struct packed {
		logic [15:0] muxed_addr_data_pins_in;
		logic parity_pin_upper_lane_in;
		logic parity_pin_lower_lane_in;
	} badp_ext_in_t;

	typedef struct packed {
		logic [7:0] refresh_control_reg;
		logic [7:0] refresh_timer_ctl_status;
		logic [7:0] refresh_counter;
		logic [7:0] refresh_constant;
		logic dram_space_enable;
	} badp_refresh_t;

endpackage : badp_pkg

// ### dv/badp_sva.sv
// badp_sva: port checks of badp_top on selects, lanes, strobes and read-back bits.
// assumes it is bound onto badp_top, one clock, synchronous low reset.
`timescale 1ns/10ps
module badp_sva (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire badp_pkg::badp_ext_out_t ext_out
);
	logic [7:0] ra_q;
	wire logic [7:0] seln = ext_out.area_select_n;
	wire logic [7:0] oe_hi = ext_out.muxed_addr_data_pins_oe[15:8];
	wire logic sel = seln != 8'hff;
	wire logic ref_rd = ra_q inside {[8'h04:8'h13]};
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// the read answer is judged by the address taken, not by what is on the bus now
	always_ff @(posedge ref_clk) begin
		if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
	end
	sequence s_strobe;
		!ext_out.wr_n [*4] ##1 ext_out.wr_n;
	endsequence
	sequence s_pcr_answer;
		s_axi_rvalid && ra_q == 8'h00;
	endsequence
	AST_SEL_ONE: assert property (sel |-> $onehot(~seln))
		else $error("several selects low");
	AST_SEL_AREA: assert property (sel |-> !seln[ext_out.addr[26:24]])
		else $error("select not of address area");
	AST_DRAM_NOSEL: assert property (!ext_out.ras_n |-> !sel)
		else $error("select low in dram cycle");
	AST_RAM_NOSEL: assert property (!seln[7] |-> !ext_out.addr[27])
		else $error("select low for on-chip ram");
	AST_MOD_NOSEL: assert property (!seln[5] |-> ext_out.addr[27])
		else $error("select low for module space");
	AST_LANE8: assert property (!seln[2] && !ext_out.addr[27] |-> oe_hi == 8'h00)
		else $error("upper pins driven on 8-bit bus");
	AST_STROBE: assert property ($fell(ext_out.wr_n) |-> s_strobe)
		else $error("write strobe length wrong");
	AST_PCR_LOW: assert property (s_pcr_answer |-> s_axi_rdata[10:0] == 11'h000)
		else $error("parity control low bits not zero");
	AST_REF_HI: assert property (s_axi_rvalid && ref_rd |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("refresh read upper bits not zero");
endmodule : badp_sva
bind badp_top badp_sva u_badp_sva (.ref_clk, .resetn, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .ext_out);

// ### dv/badp_mem.sv
// badp_mem: even-parity external memory answering reads on the pins.
// assumes bad is held by the bench to model a failing device.
`timescale 1ns/10ps
module badp_mem (
	input wire logic ref_clk,
	input wire badp_pkg::badp_ext_out_t ext_out,
	input wire logic bad,
	output badp_pkg::badp_ext_in_t ext_in
);
	logic [15:0] d;
	badp_pkg::badp_ext_in_t q = '0;
	wire logic rd_sel = ext_out.area_select_n != 8'hff && ext_out.wr_n;
	assign ext_in = q;
	// released pins show the inverse of the last value, not a held copy
	always @(posedge ref_clk) begin
		d = rd_sel ? {~ext_out.addr[7:0], ext_out.addr[7:0]} : ~q.muxed_addr_data_pins_in;
		q <= {d, ^d[15:8] ^ bad, ^d[7:0] ^ bad};
	end
endmodule : badp_mem

// ### dv/badp_tb_top.sv
// badp_tb_top: register and cpu access tests of badp_top.
// assumes badp_mem on the pins and badp_sva bound to the design.
`timescale 1ns/10ps
module badp_tb_top;
	logic ref_clk;
	logic resetn = 1'b0;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, sels, a;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = '0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, bad = 0, st_q = 1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_ready;
	logic [1:0] s_axi_bresp, s_axi_rresp, par, rr, br;
	logic [2:0] boot_mode_pins = '0;
	badp_pkg::badp_cpu_req_t cpu_req = '0;
	badp_pkg::badp_cpu_rsp_t cpu_rsp;
	badp_pkg::badp_ext_in_t ext_in;
	badp_pkg::badp_ext_out_t ext_out;
	badp_pkg::badp_refresh_t refresh_regs;
	int failures = 0, n_compared = 0, beats;
	logic [7:0] key [4] = '{badp_pkg::BADP_KEY_REFRESH_CTL, badp_pkg::BADP_KEY_REFRESH_TCS,
		badp_pkg::BADP_KEY_REFRESH_CNT, badp_pkg::BADP_KEY_REFRESH_CONST};
	badp_top u_badp_top (.*);
	badp_mem u_badp_mem (.ref_clk, .ext_out, .bad, .ext_in);
	initial begin
		ref_clk = 0;
		forever #4 ref_clk = ~ref_clk;
	end
	// a beat is one fall of the read, write or cas strobe; in dram cycles cas falls together with the read or write strobe
	always @(posedge ref_clk) begin
		st_q <= ext_out.rd_n & ext_out.wr_n & ext_out.cas_n;
		if (st_q && !(ext_out.rd_n & ext_out.wr_n & ext_out.cas_n)) beats++;
		sels |= ~ext_out.area_select_n;
		if (!ext_out.wr_n) par = {ext_out.parity_pin_upper_lane_out, ext_out.parity_pin_lower_lane_out};
	end
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			failures++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic axw(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] s);
		@(posedge ref_clk);
		s_axi_awaddr <= ad;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge ref_clk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		br = s_axi_bresp;
		s_axi_bready <= 0;
	endtask : axw
	task automatic rdc(input logic [7:0] ad, input logic [31:0] e);
		@(posedge ref_clk);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge ref_clk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		rr = s_axi_rresp;
		s_axi_rready <= 0;
		chk("rdata", s_axi_rdata, e);
	endtask : rdc
	task automatic acc(input logic w, input logic [1:0] sz, input logic [31:0] ad, input int eb,
		input logic [7:0] es);
		@(posedge ref_clk);
		beats = 0;
		sels = '0;
		cpu_req <= '{1'b1, w, badp_pkg::badp_size_t'(sz), ad, 32'h000000a7};
		do @(posedge ref_clk); while (!cpu_ready);
		cpu_req.valid <= 0;
		do @(posedge ref_clk); while (!cpu_rsp.done);
		rd = cpu_rsp.rdata;
		chk("internal", cpu_rsp.internal, eb == 0);
		chk("beats", beats, eb);
		chk("selects", sels, es);
	endtask : acc
	task automatic test_done();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : test_done
	initial begin
		repeat (3) @(posedge ref_clk);
		resetn <= 1'b1;
		rdc(8'h00, 32'h0);
		for (int i = 0; i < 4; i++) begin
			a = 8'h04 + 8'(4 * i);
			rdc(a, i == 3 ? 32'hff : 32'h0);
			axw(a, {16'h0, key[i], 8'h3c}, 4'hf);
			axw(a, {16'h0, ~key[i], 8'hc3}, 4'hf);
			axw(a, {16'h0, key[i], 8'hc3}, 4'h1);
			rdc(a, 32'h3c);
			chk("refresh", refresh_regs[32 - 8 * i -: 8], 32'h3c);
		end
		rdc(8'h18, 32'h0);
		chk("rresp", rr, 2'h2);
		axw(8'h18, 32'h0, 4'hf);
		chk("bresp", br, 2'h2);
		axw(8'h00, 32'h7fff, 4'hf);
		rdc(8'h00, 32'h7800);
		axw(8'h00, 32'h0, 4'hf);
		acc(0, 0, 32'h02000013, 1, 8'h04);
		chk("rdata", rd, 32'h13);
		acc(0, 0, 32'h0a000002, 1, 8'h04);
		chk("rdata", rd, 32'hfd);
		acc(1, 2, 32'h03000000, 4, 8'h08);
		acc(1, 2, 32'h0b000000, 2, 8'h08);
		acc(1, 1, 32'h04000000, 2, 8'h10);
		acc(1, 1, 32'h0e000000, 1, 8'h40);
		acc(1, 1, 32'h06000000, 2, 8'h40);
		acc(1, 1, 32'h06004000, 1, 8'h40);
		acc(1, 2, 32'h0f000000, 0, 8'h00);
		acc(1, 1, 32'h07000000, 2, 8'h80);
		acc(1, 1, 32'h0d000000, 1, 8'h20);
		acc(0, 1, 32'h05000100, 0, 8'h00);
		acc(1, 1, 32'hf1000000, 2, 8'h02);
		for (int m = 0; m < 3; m++) begin
			boot_mode_pins <= 3'(m);
			repeat (4) @(posedge ref_clk);
			acc(1, 2, 32'h0, m == 0 ? 4 : m == 1 ? 2 : 0, m == 2 ? 8'h00 : 8'h01);
		end
		axw(8'h14, 32'h1, 4'hf);
		chk("dram", refresh_regs.dram_space_enable, 1'b1);
		acc(1, 1, 32'h09000000, 1, 8'h00);
		axw(8'h00, 32'h0800, 4'hf);
		acc(0, 0, 32'h02000000, 1, 8'h04);
		rdc(8'h00, 32'h0800);
		axw(8'h00, 32'h1000, 4'hf);
		acc(1, 0, 32'h02000000, 1, 8'h04);
		chk("parity", par[0], 1'b1);
		acc(0, 0, 32'h02000000, 1, 8'h04);
		rdc(8'h00, 32'h1000);
		bad <= 1;
		acc(0, 0, 32'h02000000, 1, 8'h04);
		axw(8'h00, 32'h1000, 4'hf);
		rdc(8'h00, 32'h9000);
		axw(8'h00, 32'h1000, 4'hf);
		rdc(8'h00, 32'h1000);
		axw(8'h00, 32'h3000, 4'hf);
		acc(1, 0, 32'h02000000, 1, 8'h04);
		chk("parity", par[0], 1'b0);
		axw(8'h00, 32'h5000, 4'hf);
		acc(1, 0, 32'h02000000, 1, 8'h04);
		chk("parity", par, 2'h3);
		test_done();
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		failures++;
		test_done();
	end
endmodule : badp_tb_top
